// [jrx_pll_regs.v]
// Register bank for receiver PLL settings and link receiver controls
`include "jrx_pll_regs_consts.vh"
module jrx_pll_regs (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [11:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata_ff,
    output reg         term_cal_start_a_ff,
    output reg         term_cal_start_b_ff,
    output reg         param_sum_method_ff,
    output reg         two_link_select_ff,
    output reg         link_map_select_ff,
    output reg         link_zero_up_ff,
    output reg         link_one_up_ff,
    output reg  [2:0]  local_subclass_ff,
    output reg  [79:0] pll_settings_ff
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg [7:0] alc_var_ff, vco_out_ff, cp_cfg_ff, bias1_ff, bias2_ff;
    reg [7:0] pd_ovr_ff, osc_cal_ff, cp_lvl_ff, var0_ff, var1_ff;
    reg       term_a_ff, term_b_ff;
    reg [7:0] jrx0_ff;
    reg [7:0] nxt_rdata;
    wire      pulse_a;
    wire      pulse_b;
    wire      wr_alc_var;
    wire      wr_vco_out;
    wire      wr_cp_cfg;
    wire      wr_bias_1;
    wire      wr_bias_2;
    wire      wr_pd_ovr;
    wire      wr_osc_cal;
    wire      wr_cp_lvl;
    wire      wr_var_0;
    wire      wr_var_1;
    wire      wr_term_a;
    wire      wr_term_b;
    wire      wr_jrx_0;
    wire      wr_jrx_1;

    function hit;
        input [11:0] a;
        input [11:0] target;
        hit = reg_wr && (a == target);
    endfunction

    // ----------------------------------------
    // Write strobes
    // ----------------------------------------
    // One decode per register, so an offset can never touch two fields
    assign wr_alc_var = hit(reg_addr, `ADDR_ALC_VAR);
    assign wr_vco_out = hit(reg_addr, `ADDR_VCO_OUT);
    assign wr_cp_cfg  = hit(reg_addr, `ADDR_CP_CFG);
    assign wr_bias_1  = hit(reg_addr, `ADDR_BIAS_1);
    assign wr_bias_2  = hit(reg_addr, `ADDR_BIAS_2);
    assign wr_pd_ovr  = hit(reg_addr, `ADDR_PD_OVR);
    assign wr_osc_cal = hit(reg_addr, `ADDR_OSC_CAL);
    assign wr_cp_lvl  = hit(reg_addr, `ADDR_CP_LVL);
    assign wr_var_0   = hit(reg_addr, `ADDR_VAR_0);
    assign wr_var_1   = hit(reg_addr, `ADDR_VAR_1);
    assign wr_term_a  = hit(reg_addr, `ADDR_TERM_A);
    assign wr_term_b  = hit(reg_addr, `ADDR_TERM_B);
    assign wr_jrx_0   = hit(reg_addr, `ADDR_JRX_0);
    assign wr_jrx_1   = hit(reg_addr, `ADDR_JRX_1);

    // ----------------------------------------
    // PLL field writes
    // ----------------------------------------
    // plain storage
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alc_var_ff <= `RST_ALC_VAR;
            vco_out_ff <= `RST_VCO_OUT;
            cp_cfg_ff  <= `RST_CP_CFG;
            bias1_ff   <= `RST_BIAS_1;
            bias2_ff   <= `RST_BIAS_2;
            pd_ovr_ff  <= `RST_PD_OVR;
            osc_cal_ff <= `RST_OSC_CAL;
            cp_lvl_ff  <= `RST_CP_LVL;
            var0_ff    <= `RST_VAR_0;
            var1_ff    <= `RST_VAR_1;
        end else begin
            if (wr_alc_var) begin
                alc_var_ff <= reg_wdata;
            end
            if (wr_vco_out) begin
                vco_out_ff <= reg_wdata;
            end
            if (wr_cp_cfg) begin
                cp_cfg_ff <= reg_wdata;
            end
            if (wr_bias_1) begin
                bias1_ff <= reg_wdata;
            end
            if (wr_bias_2) begin
                bias2_ff <= reg_wdata & `MASK_BIAS_2;
            end
            if (wr_pd_ovr) begin
                pd_ovr_ff <= reg_wdata;
            end
            if (wr_osc_cal) begin
                osc_cal_ff <= reg_wdata;
            end
            if (wr_cp_lvl) begin
                cp_lvl_ff <= reg_wdata & `MASK_CP_LVL;
            end
            if (wr_var_0) begin
                var0_ff <= reg_wdata & `MASK_VAR_0;
            end
            if (wr_var_1) begin
                var1_ff <= reg_wdata & `MASK_VAR_1;
            end
        end
    end

    // ----------------------------------------
    // Termination trigger writes
    // ----------------------------------------
    // stored trigger levels
    // The level is kept, so a second launch needs a write of zero first
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            term_a_ff <= 1'b0;
            term_b_ff <= 1'b0;
        end else begin
            if (wr_term_a) begin
                term_a_ff <= reg_wdata[`BIT_TERM_GO];
            end
            if (wr_term_b) begin
                term_b_ff <= reg_wdata[`BIT_TERM_GO];
            end
        end
    end

    // ----------------------------------------
    // Link receiver control writes
    // ----------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            jrx0_ff           <= `RST_JRX_0;
            local_subclass_ff <= `RST_SUBCLASS;
        end else begin
            if (wr_jrx_0) begin
                jrx0_ff <= reg_wdata & `MASK_JRX_0;
            end
            if (wr_jrx_1) begin
                local_subclass_ff <= reg_wdata[`SUB_MSB:0];
            end
        end
    end

    // ----------------------------------------
    // Calibration launch
    // ----------------------------------------
    // edge starts calibration
    rise_pulse u_rise_a (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .level    (term_a_ff),
        .pulse_ff (pulse_a)
    );
    rise_pulse u_rise_b (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .level    (term_b_ff),
        .pulse_ff (pulse_b)
    );

    // ----------------------------------------
    // Readback
    // ----------------------------------------
    // Unmapped offsets read zero; reserved bits are masked on write
    always @* begin
        case (reg_addr)
            `ADDR_ALC_VAR: nxt_rdata = alc_var_ff;
            `ADDR_VCO_OUT: nxt_rdata = vco_out_ff;
            `ADDR_CP_CFG:  nxt_rdata = cp_cfg_ff;
            `ADDR_BIAS_1:  nxt_rdata = bias1_ff;
            `ADDR_BIAS_2:  nxt_rdata = bias2_ff;
            `ADDR_PD_OVR:  nxt_rdata = pd_ovr_ff;
            `ADDR_OSC_CAL: nxt_rdata = osc_cal_ff;
            `ADDR_CP_LVL:  nxt_rdata = cp_lvl_ff;
            `ADDR_VAR_0:   nxt_rdata = var0_ff;
            `ADDR_VAR_1:   nxt_rdata = var1_ff;
            `ADDR_TERM_A:  nxt_rdata = {7'h00, term_a_ff};
            `ADDR_TERM_B:  nxt_rdata = {7'h00, term_b_ff};
            `ADDR_JRX_0:   nxt_rdata = jrx0_ff;
            `ADDR_JRX_1:   nxt_rdata = {5'h00, local_subclass_ff};
            default:       nxt_rdata = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff        <= 8'h00;
            term_cal_start_a_ff <= 1'b0;
            term_cal_start_b_ff <= 1'b0;
            param_sum_method_ff <= 1'b0;
            two_link_select_ff  <= 1'b0;
            link_map_select_ff  <= 1'b0;
            link_zero_up_ff     <= 1'b0;
            link_one_up_ff      <= 1'b0;
            pll_settings_ff     <= 80'h0;
        end else begin
            if (reg_rd) reg_rdata_ff <= nxt_rdata;
            term_cal_start_a_ff <= pulse_a;
            term_cal_start_b_ff <= pulse_b;
            param_sum_method_ff <= jrx0_ff[`BIT_SUM_METHOD];
            two_link_select_ff  <= jrx0_ff[`BIT_TWO_LINK];
            link_map_select_ff  <= jrx0_ff[`BIT_MAP_SEL];
            link_zero_up_ff     <= jrx0_ff[`BIT_EN_ZERO];
            // link one gated by dual mode
            link_one_up_ff      <= jrx0_ff[`BIT_EN_ONE] & jrx0_ff[`BIT_TWO_LINK];
            pll_settings_ff     <= {alc_var_ff, vco_out_ff, cp_cfg_ff, bias1_ff, bias2_ff,
                                    pd_ovr_ff, osc_cal_ff, cp_lvl_ff, var0_ff, var1_ff};
        end
    end
endmodule

// [jrx_pll_regs_consts.vh]
// Constants for the receiver PLL and link control register bank
// What this block does
// - A zero-to-one write on bit 0 of either termination trigger register starts one calibration for that block; holding one starts nothing more.
// - The checksum method bit picks sum of fields when zero and sum of octets when one.
// - The link mode bit picks single link when zero and dual link when one, and resets to zero.
// - The link map select bit steers host accesses to the link zero map or the link one map.
// - Enable bit 0 brings up link zero and enable bit 1 brings up link one.
// - Link one can be brought up only in dual link mode.
// - The two links come up independently whether enabled in one write or in two.
`ifndef JRX_PLL_REGS_CONSTS_VH
`define JRX_PLL_REGS_CONSTS_VH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define ADDR_ALC_VAR    12'h290
`define ADDR_VCO_OUT    12'h291
`define ADDR_CP_CFG     12'h294
`define ADDR_BIAS_1     12'h296
`define ADDR_BIAS_2     12'h297
`define ADDR_PD_OVR     12'h299
`define ADDR_OSC_CAL    12'h29a
`define ADDR_CP_LVL     12'h29c
`define ADDR_VAR_0      12'h29f
`define ADDR_VAR_1      12'h2a0
`define ADDR_TERM_A     12'h2a7
`define ADDR_TERM_B     12'h2ae
`define ADDR_JRX_0      12'h300
`define ADDR_JRX_1      12'h301
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ALC_VAR     8'h83
`define RST_VCO_OUT     8'h49
`define RST_CP_CFG      8'hb0
`define RST_BIAS_1      8'h0c
`define RST_BIAS_2      8'h00
`define RST_PD_OVR      8'h00
`define RST_OSC_CAL     8'hfe
`define RST_CP_LVL      8'h17
`define RST_VAR_0       8'h33
`define RST_VAR_1       8'h08
`define RST_JRX_0       8'h00
`define RST_SUBCLASS    3'h1
// ----------------------------------------
// Writable masks and field positions
// ----------------------------------------
`define MASK_BIAS_2     8'h3f
`define MASK_CP_LVL     8'h7f
`define MASK_VAR_0      8'h7f
`define MASK_VAR_1      8'h0f
`define MASK_JRX_0      8'h7f
`define BIT_TERM_GO     0
`define BIT_SUM_METHOD  6
`define BIT_TWO_LINK    3
`define BIT_MAP_SEL     2
`define BIT_EN_ZERO     0
`define BIT_EN_ONE      1
`define SUB_MSB         2
`endif

// [rise_pulse.v]
// One-cycle pulse on a zero-to-one change of a stored level
module rise_pulse (
    input  wire core_clk,
    input  wire rst_n,
    input  wire level,
    output reg  pulse_ff
);
    reg level_d_ff;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_d_ff <= 1'b0;
            pulse_ff   <= 1'b0;
        end else begin
            level_d_ff <= level;
            pulse_ff   <= level & ~level_d_ff;
        end
    end
endmodule

// [jrx_pll_regs_props.sv]
// Port-level checks for the PLL and link control register bank
module jrx_pll_regs_props (
    input logic        core_clk,
    input logic        rst_n,
    input logic        reg_wr,
    input logic [11:0] reg_addr,
    input logic [7:0]  reg_wdata,
    input logic        term_cal_start_a_ff,
    input logic        term_cal_start_b_ff,
    input logic        param_sum_method_ff,
    input logic        two_link_select_ff,
    input logic        link_zero_up_ff,
    input logic        link_one_up_ff,
    input logic [2:0]  local_subclass_ff
);
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_n);
wire w0 = reg_wr && reg_addr == 12'h300;
wire w1 = reg_wr && reg_addr == 12'h301;
term_a_cause_a: assert property (term_cal_start_a_ff |->
    $past(reg_wr && reg_addr == 12'h2a7 && reg_wdata[0], 3)) else $error("cal a no write");
term_b_cause_a: assert property (term_cal_start_b_ff |->
    $past(reg_wr && reg_addr == 12'h2ae && reg_wdata[0], 3)) else $error("cal b no write");
cal_single_a: assert property (term_cal_start_a_ff |=> !term_cal_start_a_ff)
    else $error("cal pulse too long");
sum_method_a: assert property (w0 |-> ##2 param_sum_method_ff == $past(reg_wdata[6], 2))
    else $error("sum method wrong");
link_mode_a: assert property (w0 |-> ##2 two_link_select_ff == $past(reg_wdata[3], 2))
    else $error("link mode wrong");
zero_up_a: assert property (w0 |-> ##2 link_zero_up_ff == $past(reg_wdata[0], 2))
    else $error("link zero wrong");
one_gated_a: assert property (w0 |-> ##2
    link_one_up_ff == $past(reg_wdata[1] & reg_wdata[3], 2)) else $error("link one wrong");
subclass_set_a: assert property (w1 |-> ##2
    local_subclass_ff == $past(reg_wdata[2:0], 2)) else $error("subclass wrong");
endmodule

// [reg_host.sv]
// Host model driving the register strobes of the bank
module reg_host (
    input  logic        core_clk,
    input  logic [7:0]  reg_rdata_ff,
    output logic        reg_wr,
    output logic        reg_rd,
    output logic [11:0] reg_addr,
    output logic [7:0]  reg_wdata
);
timeunit 1ns;
timeprecision 1ns;
initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
end
task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // Released data toggles so stale values are not trusted
    reg_wdata <= ~d;
endtask
task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    #1;
    d = reg_rdata_ff;
endtask
endmodule

// [tb_jrx_pll_regs.sv]
// Self-checking bench for the PLL and link control register bank
module tb_jrx_pll_regs;
timeunit 1ns;
timeprecision 1ns;
logic core_clk = 1'b0;
logic rst_n = 1'b0;
wire reg_wr, reg_rd, term_cal_start_a_ff, term_cal_start_b_ff, param_sum_method_ff;
wire two_link_select_ff, link_map_select_ff, link_zero_up_ff, link_one_up_ff;
wire [11:0] reg_addr;
wire [7:0] reg_wdata, reg_rdata_ff;
wire [2:0] local_subclass_ff;
wire [79:0] pll_settings_ff;
int failures = 0;
int checks_done = 0;
int na = 0;
int nb = 0;
logic [7:0] rv;
logic [11:0] ad [10] = '{12'h290, 12'h291, 12'h294, 12'h296, 12'h297, 12'h299, 12'h29a,
    12'h29c, 12'h29f, 12'h2a0};
logic [7:0] rs [10] = '{8'h83, 8'h49, 8'hb0, 8'h0c, 8'h00, 8'h00, 8'hfe, 8'h17, 8'h33, 8'h08};
logic [7:0] mk [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'h0f};
jrx_pll_regs jrx_pll_regs_inst (.core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_ff, .term_cal_start_a_ff, .term_cal_start_b_ff, .param_sum_method_ff,
    .two_link_select_ff, .link_map_select_ff, .link_zero_up_ff, .link_one_up_ff,
    .local_subclass_ff, .pll_settings_ff);
reg_host reg_host_inst (.core_clk, .reg_rdata_ff, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
always #50 core_clk = ~core_clk;
always @(posedge core_clk) begin
    na += term_cal_start_a_ff;
    nb += term_cal_start_b_ff;
end
task automatic chk(input string n, input logic [79:0] e, input logic [79:0] g);
    checks_done++;
    if (g !== e) begin
        failures++;
        $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
endtask
task automatic t_pll(input bit wr_all);
    logic [79:0] e;
    e = '0;
    for (int i = 0; i < 10; i++) begin
        if (wr_all) reg_host_inst.wr(ad[i], 8'hff);
        reg_host_inst.rd(ad[i], rv);
        chk("pll reg", wr_all ? mk[i] : rs[i], rv);
        e = {e[71:0], wr_all ? mk[i] : rs[i]};
    end
    chk("pll settings", e, pll_settings_ff);
    chk("subclass", wr_all ? 3'h1 : 3'h1, local_subclass_ff);
    $display("test pll done");
endtask
task automatic t_term();
    reg_host_inst.wr(12'h2a7, 8'h01);
    reg_host_inst.wr(12'h2a7, 8'hff);
    reg_host_inst.wr(12'h2ae, 8'h01);
    reg_host_inst.wr(12'h2a7, 8'h00);
    reg_host_inst.wr(12'h2a7, 8'h01);
    repeat (5) @(posedge core_clk);
    #1;
    chk("cal a pulses", 2, na);
    chk("cal b pulses", 1, nb);
    reg_host_inst.rd(12'h2a7, rv);
    chk("term readback", 8'h01, rv);
    $display("test term done");
endtask
task automatic t_links();
    logic [7:0] v [8] = '{8'h02, 8'h08, 8'h09, 8'h0b, 8'h0a, 8'h44, 8'hff, 8'h00};
    foreach (v[i]) begin
        reg_host_inst.wr(12'h300, v[i]);
        reg_host_inst.rd(12'h300, rv);
        chk("ctrl readback", v[i] & 8'h7f, rv);
        chk("ctrl outputs", {v[i][6], v[i][3], v[i][2], v[i][0], v[i][1] & v[i][3]},
            {param_sum_method_ff, two_link_select_ff, link_map_select_ff, link_zero_up_ff,
            link_one_up_ff});
    end
    $display("test links done");
endtask
task automatic t_sub();
    reg_host_inst.wr(12'h301, 8'hf8);
    reg_host_inst.rd(12'h301, rv);
    chk("subclass readback", 8'h00, rv);
    chk("subclass", 3'h0, local_subclass_ff);
    reg_host_inst.wr(12'h2ff, 8'hff);
    reg_host_inst.rd(12'h2ff, rv);
    chk("unmapped read", 8'h00, rv);
    $display("test sub done");
endtask
task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask
initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_pll(1'b0);
    t_pll(1'b1);
    t_term();
    t_links();
    t_sub();
    final_report();
end
initial begin
    #2000000;
    failures++;
    final_report();
end
endmodule
bind jrx_pll_regs jrx_pll_regs_props jrx_pll_regs_props_inst (.core_clk, .rst_n, .reg_wr,
    .reg_addr, .reg_wdata, .term_cal_start_a_ff, .term_cal_start_b_ff, .param_sum_method_ff,
    .two_link_select_ff, .link_zero_up_ff, .link_one_up_ff, .local_subclass_ff);
